// *** hdl/utdma_pkg.sv ***
package utdma_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned AW        = 16;
  localparam int unsigned DW        = 32;
  localparam logic [15:0] DEF_OFS   = 16'hffe0;  // tx_dma_channel_definition
  localparam logic [15:0] STAT_OFS  = 16'hffe4;  // tx_dma_status, write one to clear
  localparam logic [15:0] MASK_OFS  = 16'hffe8;  // interrupt mask, same layout
  localparam logic [15:0] TMO_OFS   = 16'hffec;  // transaction timer reload

  // ----------------------------------------------------------------
  // definition register fields
  // ----------------------------------------------------------------
  localparam int unsigned PTR_LSB   = 0;
  localparam int unsigned PTR_W     = 3;
  localparam int unsigned DIR_BIT   = 3;
  localparam int unsigned XY_BIT    = 4;
  localparam int unsigned CNT_BIT   = 5;
  localparam int unsigned INE_BIT   = 6;
  localparam int unsigned EN_BIT    = 7;
  localparam int unsigned DEF_W     = 8;

  // ----------------------------------------------------------------
  // status and mask fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_PARTIAL_PACKET_FLAG   = 0;  // partial_packet_flag
  localparam int unsigned ST_DONE   = 1;  // enable fell with irq enabled
  localparam int unsigned ST_TMO    = 2;  // transaction timer expired
  localparam int unsigned ST_W      = 3;

  // ----------------------------------------------------------------
  // transaction timer
  // ----------------------------------------------------------------
  localparam int unsigned TMO_W     = 16;
  localparam logic [15:0] TMO_RST   = 16'hffff;

  // ----------------------------------------------------------------
  // sram and endpoint_descriptor_block layout
  // ----------------------------------------------------------------
  localparam int unsigned MA_W      = 11;
  localparam logic [10:0] DESC_BASE = 11'h780;
  localparam logic [2:0]  F_XBASE   = 3'h1;
  localparam logic [2:0]  F_XCNT    = 3'h2;
  localparam logic [2:0]  F_SIZE    = 3'h3;
  localparam logic [2:0]  F_YBASE   = 3'h4;
  localparam logic [2:0]  F_YCNT    = 3'h5;
  localparam int unsigned NAK_BIT   = 7;
  localparam int unsigned BCNT_W    = 7;

  typedef enum logic [3:0] {
    S_IDLE, S_CNT, S_SIZE, S_BASE, S_FETCH, S_SEND, S_WBACK, S_NEXT
  } utdma_state_t;

  // byte address of one field of a descriptor block
  function automatic logic [10:0] desc_addr(input logic [2:0] ptr, input logic [2:0] fld);
    desc_addr = DESC_BASE + {5'h00, ptr, fld};
  endfunction

endpackage

// *** hdl/utdma_mem_if.sv ***
interface utdma_mem_if;
  logic                       req;
  logic                       we;
  logic [utdma_pkg::MA_W-1:0] addr;
  logic [7:0]                 wdata;
  logic [7:0]                 rdata;
  logic                       done;

  modport client (output req, we, addr, wdata, input rdata, done);
  modport port   (input req, we, addr, wdata, output rdata, done);
endinterface

// *** hdl/utdma_mem_port.sv ***
module utdma_mem_port (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  utdma_mem_if.port                       mem,
  output logic                            sram_req_o,
  output logic                            sram_we_o,
  output logic [utdma_pkg::MA_W-1:0]      sram_addr_o,
  output logic [7:0]                      sram_wdata_o,
  input  wire logic [7:0]                 sram_rdata_i,
  input  wire logic                       sram_ack_i
);

  // ----------------------------------------------------------------
  // one access at a time: latch the request, hold it until ack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sram_req_o   <= 1'b0;
      sram_we_o    <= 1'b0;
      sram_addr_o  <= '0;
      sram_wdata_o <= 8'h00;
      mem.rdata    <= 8'h00;
      mem.done     <= 1'b0;
    end else begin
      mem.done <= 1'b0;
      if (sram_req_o) begin
        if (sram_ack_i) begin
          sram_req_o <= 1'b0;
          mem.rdata  <= sram_rdata_i;
          mem.done   <= 1'b1;
        end
      end else if (mem.req) begin
        sram_req_o   <= 1'b1;
        sram_we_o    <= mem.we;
        sram_addr_o  <= mem.addr;
        sram_wdata_o <= mem.wdata;
      end
    end
  end

endmodule

// *** hdl/utdma_timer.sv ***
module utdma_timer (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        run_i,
  input  wire logic                        kick_i,
  input  wire logic [utdma_pkg::TMO_W-1:0] reload_i,
  output logic                             expired_o
);

  logic [utdma_pkg::TMO_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // reload while stopped or on progress, flag expiry at zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q     <= '0;
      expired_o <= 1'b0;
    end else if (!run_i || kick_i) begin
      cnt_q     <= reload_i;
      expired_o <= 1'b0;
    end else if (cnt_q == '0) begin
      expired_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

endmodule

// *** hdl/utdma_channel.sv ***
module utdma_channel (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [utdma_pkg::AW-1:0]    wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [utdma_pkg::DW-1:0]    wb_dat_i,
  output logic      [utdma_pkg::DW-1:0]    wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             sram_req_o,
  output logic                             sram_we_o,
  output logic      [utdma_pkg::MA_W-1:0]  sram_addr_o,
  output logic      [7:0]                  sram_wdata_o,
  input  wire logic [7:0]                  sram_rdata_i,
  input  wire logic                        sram_ack_i,
  input  wire logic                        uart_thr_ready_i,
  output logic      [7:0]                  uart_thr_data_o,
  output logic                             uart_thr_wr_o,
  output logic                             irq_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                                    wb_ack_q;
  logic [utdma_pkg::DW-1:0]                wb_dat_q;
  logic [utdma_pkg::DW-1:0]                rd_d;
  logic                                    wb_req;
  logic                                    wr_go;
  logic                                    wr_def;
  logic                                    wr_stat;
  logic                                    wr_mask;
  logic                                    wr_tmo;

  logic [utdma_pkg::PTR_W-1:0]             ptr_q;
  logic                                    xy_q;
  logic                                    cont_q;
  logic                                    ine_q;
  logic                                    en_q;
  logic                                    en_prev_q;
  logic [utdma_pkg::DEF_W-1:0]             def_rd;
  logic [utdma_pkg::ST_W-1:0]              status_q;
  logic [utdma_pkg::ST_W-1:0]              mask_q;
  logic [utdma_pkg::ST_W-1:0]              st_set;
  logic [utdma_pkg::ST_W-1:0]              st_clr;
  logic [utdma_pkg::TMO_W-1:0]             tmo_q;
  logic                                    irq_q;

  utdma_pkg::utdma_state_t                 state_q;
  logic                                    busy_q;
  logic                                    have_buf_q;
  logic                                    term_q;
  logic [utdma_pkg::BCNT_W-1:0]            cnt_q;
  logic [utdma_pkg::BCNT_W-1:0]            remain_q;
  logic [7:0]                              size_q;
  logic [utdma_pkg::MA_W-1:0]              addr_q;
  logic [7:0]                              thr_data_q;
  logic                                    thr_wr_q;
  logic                                    mreq_q;
  logic                                    mwe_q;
  logic [utdma_pkg::MA_W-1:0]              maddr_q;
  logic [7:0]                              mwdata_q;

  logic [utdma_pkg::MA_W-1:0]              cnt_addr;
  logic                                    short_pkt;
  logic                                    in_next;
  logic                                    xy_tgl;
  logic                                    en_clr;
  logic                                    partial_packet_flag_set;
  logic                                    tmo_set;
  logic                                    tmo_exp;
  logic                                    tmr_run;
  logic                                    tmr_kick;

  utdma_mem_if                             mem_bus ();

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // a write lands at the edge where the master sees ack
  assign wb_req  = wb_cyc_i & wb_stb_i;
  assign wr_go   = wb_req & wb_we_i & wb_ack_q;
  assign wr_def  = wr_go & (wb_adr_i == utdma_pkg::DEF_OFS) & wb_sel_i[0];
  assign wr_stat = wr_go & (wb_adr_i == utdma_pkg::STAT_OFS) & wb_sel_i[0];
  assign wr_mask = wr_go & (wb_adr_i == utdma_pkg::MASK_OFS) & wb_sel_i[0];
  assign wr_tmo  = wr_go & (wb_adr_i == utdma_pkg::TMO_OFS);

  // read view of the definition register
  always_comb begin
    def_rd                                           = '0;
    def_rd[utdma_pkg::PTR_LSB +: utdma_pkg::PTR_W]   = ptr_q;
    def_rd[utdma_pkg::DIR_BIT]                       = 1'b1;
    def_rd[utdma_pkg::XY_BIT]                        = xy_q;
    def_rd[utdma_pkg::CNT_BIT]                       = cont_q;
    def_rd[utdma_pkg::INE_BIT]                       = ine_q;
    def_rd[utdma_pkg::EN_BIT]                        = en_q;
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    case (wb_adr_i)
      utdma_pkg::DEF_OFS:  rd_d[utdma_pkg::DEF_W-1:0] = def_rd;
      utdma_pkg::STAT_OFS: rd_d[utdma_pkg::ST_W-1:0]  = status_q;
      utdma_pkg::MASK_OFS: rd_d[utdma_pkg::ST_W-1:0]  = mask_q;
      utdma_pkg::TMO_OFS:  rd_d[utdma_pkg::TMO_W-1:0] = tmo_q;
      default:             rd_d = '0;
    endcase
  end

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
    end else begin
      wb_ack_q <= wb_req & ~wb_ack_q;
      if (wb_req && !wb_ack_q) begin
        wb_dat_q <= rd_d;
      end
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ----------------------------------------------------------------
  // definition register
  // ----------------------------------------------------------------
  // a bus write takes the cycle; hardware updates apply otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q  <= '0;
      xy_q   <= 1'b0;
      cont_q <= 1'b0;
      ine_q  <= 1'b0;
      en_q   <= 1'b0;
    end else if (wr_def) begin
      ptr_q  <= wb_dat_i[utdma_pkg::PTR_LSB +: utdma_pkg::PTR_W];
      xy_q   <= wb_dat_i[utdma_pkg::XY_BIT];
      cont_q <= wb_dat_i[utdma_pkg::CNT_BIT];
      ine_q  <= wb_dat_i[utdma_pkg::INE_BIT];
      en_q   <= wb_dat_i[utdma_pkg::EN_BIT];
    end else begin
      if (xy_tgl) begin
        xy_q <= ~xy_q;
      end
      if (en_clr) begin
        en_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status, mask, timer reload and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    st_set                     = '0;
    st_set[utdma_pkg::ST_PARTIAL_PACKET_FLAG] = partial_packet_flag_set;
    st_set[utdma_pkg::ST_DONE] = en_prev_q & ~en_q & ine_q;
    st_set[utdma_pkg::ST_TMO]  = tmo_set;
    st_clr                     = wr_stat ? wb_dat_i[utdma_pkg::ST_W-1:0] : '0;
  end

  // sticky bits, a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q  <= '0;
      en_prev_q <= 1'b0;
    end else begin
      status_q  <= (status_q & ~st_clr) | st_set;
      en_prev_q <= en_q;
    end
  end

  // mask and transaction timer reload value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
      tmo_q  <= utdma_pkg::TMO_RST;
    end else begin
      if (wr_mask) begin
        mask_q <= wb_dat_i[utdma_pkg::ST_W-1:0];
      end
      if (wr_tmo && wb_sel_i[0]) begin
        tmo_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_tmo && wb_sel_i[1]) begin
        tmo_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // decisions at the end of a buffer
  // ----------------------------------------------------------------
  assign cnt_addr  = utdma_pkg::desc_addr(ptr_q, xy_q ? utdma_pkg::F_YCNT : utdma_pkg::F_XCNT);
  assign short_pkt = ({1'b0, cnt_q} < size_q);
  assign in_next   = (state_q == utdma_pkg::S_NEXT);
  assign xy_tgl    = in_next & have_buf_q & ~term_q;
  assign en_clr    = in_next & (term_q | (short_pkt & ine_q));
  assign partial_packet_flag_set  = in_next & have_buf_q & ~term_q & short_pkt;
  assign tmo_set   = in_next & term_q;
  assign tmr_run   = (state_q != utdma_pkg::S_IDLE);
  assign tmr_kick  = ((state_q == utdma_pkg::S_SEND) & uart_thr_ready_i) |
                     ((state_q == utdma_pkg::S_CNT) & busy_q & mem_bus.done &
                      mem_bus.rdata[utdma_pkg::NAK_BIT]);

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  // each sram state issues one access, then waits for done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= utdma_pkg::S_IDLE;
      busy_q     <= 1'b0;
      have_buf_q <= 1'b0;
      term_q     <= 1'b0;
      cnt_q      <= '0;
      remain_q   <= '0;
      size_q     <= 8'h00;
      addr_q     <= '0;
      thr_data_q <= 8'h00;
      thr_wr_q   <= 1'b0;
      mreq_q     <= 1'b0;
      mwe_q      <= 1'b0;
      maddr_q    <= '0;
      mwdata_q   <= 8'h00;
    end else begin
      mreq_q   <= 1'b0;
      thr_wr_q <= 1'b0;
      case (state_q)
        utdma_pkg::S_IDLE: begin
          busy_q     <= 1'b0;
          have_buf_q <= 1'b0;
          term_q     <= 1'b0;
          if (en_q) begin
            state_q <= utdma_pkg::S_CNT;
          end
        end
        utdma_pkg::S_CNT: begin
          if (!busy_q) begin
            if (!en_q) begin
              state_q <= utdma_pkg::S_IDLE;
            end else if (tmo_exp) begin
              term_q  <= 1'b1;
              state_q <= utdma_pkg::S_NEXT;
            end else begin
              mreq_q  <= 1'b1;
              mwe_q   <= 1'b0;
              maddr_q <= cnt_addr;
              busy_q  <= 1'b1;
            end
          end else if (mem_bus.done) begin
            busy_q <= 1'b0;
            if (mem_bus.rdata[utdma_pkg::NAK_BIT]) begin
              cnt_q      <= mem_bus.rdata[utdma_pkg::BCNT_W-1:0];
              remain_q   <= mem_bus.rdata[utdma_pkg::BCNT_W-1:0];
              have_buf_q <= 1'b1;
              state_q    <= utdma_pkg::S_SIZE;
            end
          end
        end
        utdma_pkg::S_SIZE: begin
          if (!busy_q) begin
            mreq_q  <= 1'b1;
            mwe_q   <= 1'b0;
            maddr_q <= utdma_pkg::desc_addr(ptr_q, utdma_pkg::F_SIZE);
            busy_q  <= 1'b1;
          end else if (mem_bus.done) begin
            busy_q  <= 1'b0;
            size_q  <= mem_bus.rdata;
            state_q <= utdma_pkg::S_BASE;
          end
        end
        utdma_pkg::S_BASE: begin
          if (!busy_q) begin
            mreq_q  <= 1'b1;
            mwe_q   <= 1'b0;
            maddr_q <= utdma_pkg::desc_addr(ptr_q, xy_q ? utdma_pkg::F_YBASE
                                                        : utdma_pkg::F_XBASE);
            busy_q  <= 1'b1;
          end else if (mem_bus.done) begin
            busy_q  <= 1'b0;
            addr_q  <= {mem_bus.rdata, 3'h0};
            state_q <= (remain_q == '0) ? utdma_pkg::S_WBACK : utdma_pkg::S_FETCH;
          end
        end
        utdma_pkg::S_FETCH: begin
          if (!busy_q) begin
            mreq_q  <= 1'b1;
            mwe_q   <= 1'b0;
            maddr_q <= addr_q;
            busy_q  <= 1'b1;
          end else if (mem_bus.done) begin
            busy_q     <= 1'b0;
            thr_data_q <= mem_bus.rdata;
            state_q    <= utdma_pkg::S_SEND;
          end
        end
        utdma_pkg::S_SEND: begin
          if (tmo_exp) begin
            term_q  <= 1'b1;
            state_q <= utdma_pkg::S_WBACK;
          end else if (uart_thr_ready_i) begin
            thr_wr_q <= 1'b1;
            remain_q <= remain_q - 7'h01;
            addr_q   <= addr_q + 11'h001;
            state_q  <= (remain_q == 7'h01) ? utdma_pkg::S_WBACK
                                            : utdma_pkg::S_FETCH;
          end
        end
        utdma_pkg::S_WBACK: begin
          if (!busy_q) begin
            mreq_q   <= 1'b1;
            mwe_q    <= 1'b1;
            maddr_q  <= cnt_addr;
            mwdata_q <= {1'b0, remain_q};
            busy_q   <= 1'b1;
          end else if (mem_bus.done) begin
            busy_q  <= 1'b0;
            state_q <= utdma_pkg::S_NEXT;
          end
        end
        utdma_pkg::S_NEXT: begin
          have_buf_q <= 1'b0;
          term_q     <= 1'b0;
          state_q    <= en_clr ? utdma_pkg::S_IDLE : utdma_pkg::S_CNT;
        end
        default: begin
          state_q <= utdma_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign mem_bus.req   = mreq_q;
  assign mem_bus.we    = mwe_q;
  assign mem_bus.addr  = maddr_q;
  assign mem_bus.wdata = mwdata_q;

  assign uart_thr_data_o = thr_data_q;
  assign uart_thr_wr_o   = thr_wr_q;

  // ----------------------------------------------------------------
  // sram access port and transaction timer
  // ----------------------------------------------------------------
  utdma_mem_port u_mem (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .mem          (mem_bus.port),
    .sram_req_o   (sram_req_o),
    .sram_we_o    (sram_we_o),
    .sram_addr_o  (sram_addr_o),
    .sram_wdata_o (sram_wdata_o),
    .sram_rdata_i (sram_rdata_i),
    .sram_ack_i   (sram_ack_i)
  );

  utdma_timer u_tmr (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (tmr_run),
    .kick_i    (tmr_kick),
    .reload_i  (tmo_q),
    .expired_o (tmo_exp)
  );

endmodule

// *** tb/utdma_channel_properties.sv ***
module utdma_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sram_req_o,
  input wire logic        sram_ack_i,
  input wire logic        uart_thr_ready_i,
  input wire logic        uart_thr_wr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request still waiting for its answer
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a read being answered
  sequence rd_done_s;
    wb_ack_o && !$past(wb_we_i);
  endsequence
  ack_latency_a: assert property (wb_req_s |=> wb_ack_o)
    else $error("bus answer not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");
  dir_read_a: assert property (rd_done_s ##0 ($past(wb_adr_i) == utdma_pkg::DEF_OFS)
    |-> wb_dat_o[3] && wb_dat_o[31:8] == 24'h000000) else $error("direction bit not one");
  unmapped_zero_a: assert property (rd_done_s ##0 ($past(wb_adr_i[15:4]) != 12'hffe)
    |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
  sram_hold_a: assert property (sram_req_o && !sram_ack_i |=> sram_req_o)
    else $error("memory request dropped early");
  sram_drop_a: assert property (sram_req_o && sram_ack_i |=> !sram_req_o)
    else $error("memory request kept after answer");
  thr_ready_a: assert property (uart_thr_wr_o |-> $past(uart_thr_ready_i))
    else $error("byte written while holding register busy");
  thr_pulse_a: assert property (uart_thr_wr_o |=> !uart_thr_wr_o)
    else $error("holding register write longer than one cycle");
endmodule

bind utdma_channel utdma_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .sram_req_o, .sram_ack_i, .uart_thr_ready_i,
  .uart_thr_wr_o);

// *** tb/utdma_sram_model.sv ***
module utdma_sram_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  output logic             ack_o,
  output logic             ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:2047];
  int         wait_q = 0;
  initial ack_o = 1'b0;
  initial rdata_o = 8'h00;
  initial ready_o = 1'b0;
  // answer after 0..3 idle cycles; stale read data is inverted
  always @(posedge clk_i) begin
    ready_o <= ($urandom % 4) != 0;
    if (ack_o) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end else if (req_i && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (req_i) begin
      ack_o <= 1'b1;
      wait_q <= $urandom % 4;
      if (we_i) mem[addr_i] <= wdata_i;
      else rdata_o <= mem[addr_i];
    end
  end
endmodule

// *** tb/uart_tx_dma_channel_test.sv ***
module uart_tx_dma_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] a_def = utdma_pkg::DEF_OFS;
  localparam logic [15:0] a_st  = utdma_pkg::STAT_OFS;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0]  wb_sel_i = 4'hf, sel = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [10:0] sram_addr_o;
  logic [7:0]  sram_wdata_o, sram_rdata_i, uart_thr_data_o, exp_q [$];
  logic        sram_req_o, sram_we_o, sram_ack_i, uart_thr_ready_i, uart_thr_wr_o, irq_o, wb_ack_o;
  int          n_errors = 0, tests_run = 0;
  always #5 clk_i = ~clk_i;
  utdma_channel u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sram_req_o, .sram_we_o, .sram_addr_o,
    .sram_wdata_o, .sram_rdata_i, .sram_ack_i, .uart_thr_ready_i, .uart_thr_data_o,
    .uart_thr_wr_o, .irq_o);
  utdma_sram_model u_mem (.clk_i, .req_i(sram_req_o), .we_i(sram_we_o), .addr_i(sram_addr_o),
    .wdata_i(sram_wdata_o), .rdata_o(sram_rdata_i), .ack_o(sram_ack_i),
    .ready_o(uart_thr_ready_i));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one classic bus cycle, released at the answering edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, sel};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      end_sim;
    end
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // random buffer contents become the expected byte stream
  task automatic fill(input logic [10:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      u_mem.mem[a + i] = 8'($urandom);
      exp_q.push_back(u_mem.mem[a + i]);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, a_def, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 200);
    chk("halted", 32'h0, rd[7]);
    if (rd[7] !== 1'b0) end_sim;
    chk("bytes left", 32'h0, exp_q.size());
  endtask
  // every byte on the holding register must be the next expected one
  always @(posedge clk_i) if (uart_thr_wr_o === 1'b1)
    chk("tx byte", exp_q.size() ? exp_q.pop_front() : 32'h1ff, uart_thr_data_o);
  initial begin
    void'($urandom(37));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("def reset", a_def, 32'h08);
    rchk("timer reset", utdma_pkg::TMO_OFS, 32'hffff);
    rchk("unmapped", 16'hfff0, 32'h0);
    wb(1'b1, a_def, 32'h23);
    rchk("def kept", a_def, 32'h2b);
    wb(1'b1, utdma_pkg::TMO_OFS, 32'h40);
    wb(1'b1, utdma_pkg::MASK_OFS, 32'h7);
    sel = 4'he;
    wb(1'b1, utdma_pkg::MASK_OFS, 32'h0);
    sel = 4'hf;
    rchk("mask lane", utdma_pkg::MASK_OFS, 32'h7);
    {u_mem.mem[11'h799], u_mem.mem[11'h79a], u_mem.mem[11'h79b]} = 24'h10_84_04;
    {u_mem.mem[11'h79c], u_mem.mem[11'h79d]} = 16'h20_82;
    fill(11'h080, 4);
    fill(11'h100, 2);
    wb(1'b1, a_def, 32'he3);
    wait_idle;
    rchk("def done", a_def, 32'h6b);
    rchk("status done", a_st, 32'h3);
    chk("irq on", 32'h1, irq_o);
    chk("x wback", 32'h0, u_mem.mem[11'h79a]);
    chk("y wback", 32'h0, u_mem.mem[11'h79d]);
    wb(1'b1, a_st, 32'h0);
    rchk("w0 kept", a_st, 32'h3);
    wb(1'b1, a_st, 32'h1);
    rchk("w1 clear", a_st, 32'h2);
    wb(1'b1, a_st, 32'h2);
    rchk("all clear", a_st, 32'h0);
    chk("irq off", 32'h0, irq_o);
    u_mem.mem[11'h79d] = 8'h82;
    fill(11'h100, 2);
    wb(1'b1, a_def, 32'hb3);
    wait_idle;
    rchk("def tmo", a_def, 32'h2b);
    rchk("status tmo", a_st, 32'h5);
    chk("irq tmo", 32'h1, irq_o);
    end_sim;
  end
endmodule
